// [pkg/lvic_pkg.sv]
// Constants for the low-voltage detector and interrupt control block.
// Assumes a core that reaches the registers as special data memory bytes.
package lvic_pkg;

    // ========================================================================
    // Register indices on the special data memory port
    localparam logic [2:0] ADDR_LVD_CTRL  = 3'h0;
    localparam logic [2:0] ADDR_INT_CTRL0 = 3'h1;
    localparam logic [2:0] ADDR_INT_CTRL1 = 3'h2;
    localparam logic [2:0] ADDR_INT_CTRL2 = 3'h3;
    localparam logic [2:0] ADDR_INT_CTRL3 = 3'h4;

    // ========================================================================
    // Low-voltage control register fields
    localparam int LVD_FLAG_BIT  = 5;
    localparam int LVD_EN_BIT    = 4;
    localparam int BG_BUF_BIT    = 3;
    localparam int THR_MSB       = 2;
    localparam int THR_LSB       = 0;
    localparam logic [7:0] LVD_WR_MASK  = 8'h1f;
    localparam logic [7:0] INTERRUPT_CONTROL_0_WR_MASK = 8'h7f;
    localparam logic [7:0] REG_RESET    = 8'h00;

    // ========================================================================
    // Interrupt control register fields
    localparam int GIE_BIT       = 0;
    localparam int C0_OVP_EN     = 1;
    localparam int C0_CMP1_EN    = 2;
    localparam int C0_PPG_EN     = 3;
    localparam int C0_OVP_FLAG   = 4;
    localparam int C0_CMP1_FLAG  = 5;
    localparam int C0_PPG_FLAG   = 6;
    localparam int EN_MSB        = 3;
    localparam int EN_LSB        = 0;
    localparam int FLAG_MSB      = 7;
    localparam int FLAG_LSB      = 4;

    // ========================================================================
    // Source numbering, index is also priority (0 highest)
    localparam int NUM_SRC      = 15;
    localparam int SRC_OVP      = 0;
    localparam int SRC_CMP1     = 1;
    localparam int SRC_CMP2     = 2;
    localparam int SRC_CMP3     = 3;
    localparam int SRC_PPG_GEN  = 4;
    localparam int SRC_PPG_TMR  = 5;
    localparam int SRC_PPG_CUT  = 6;
    localparam int SRC_PPG_RETR = 7;
    localparam int SRC_ADC      = 8;
    localparam int SRC_EEPROM   = 9;
    localparam int SRC_LVD      = 10;
    localparam int SRC_TMR0     = 11;
    localparam int SRC_TMR1     = 12;
    localparam int SRC_TMR2     = 13;
    localparam int SRC_I2C      = 14;

    // ========================================================================
    // Timing
    localparam int CLK_MHZ            = 25;
    localparam int LOW_SUPPLY_DLY_US  = 20;
    localparam int LOW_SUPPLY_DLY_CYC = LOW_SUPPLY_DLY_US * CLK_MHZ;

    // Detector states
    typedef enum logic [1:0] {
        DET_IDLE  = 2'b00,
        DET_WAIT  = 2'b01,
        DET_FIRED = 2'b10
    } lvic_det_type;

endpackage : lvic_pkg

// [hw/lvic_top.sv]
// Interrupt enable/flag registers and low-voltage detector control.
// Assumes the core issues single-cycle byte reads and writes on the
// special data port and pulses the acknowledge when it vectors.
//
// Functional notes
// - Three-bit threshold select picks one of eight levels, 2.0V to 4.0V.
// - Read-only low-supply flag, bit 5, is 1 while detector on and supply below threshold.
// - Bit 4 powers the detector at 1, switches it off at 0.
// - Bandgap on when enable bit 4 set (even in sleep), low-voltage reset on, or bit 3 set.
// - Bits 7 and 6 of low-voltage control always read zero.
// - Detector is forced off during sleep regardless of enable bit.
// - Low-supply irq flag set only after fixed delay following flag rising.
// - Set low-supply irq flag wakes from idle; a preset flag wakes at once.
// - Four byte registers; each source has its own flag and enable.
// - First register: flags in bits 6..4, enables 3..1, bit 7 zero.
// - Second register: comparator 3, 2, ADC, timer 0 flags and enables.
// - Third and fourth registers: EEPROM/timers/LVD and I2C/pulse sources.
// - A flag with its enable clear stays recorded and raises no interrupt.
// - Servicing clears global enable; new requests still set flags.
// - Servicing clears the serviced source's request flag.
// - Any set request flag wakes from sleep or idle, regardless of enables.
`timescale 1ns/1ps

module lvic_top #(
    parameter int DLY_CYC = lvic_pkg::LOW_SUPPLY_DLY_CYC
) (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    // Special data memory port
    input  wire logic [2:0]  i_addr,
    input  wire logic        i_wr,
    input  wire logic [7:0]  i_wdata,
    output logic      [7:0]  o_rdata,
    // Peripheral event pulses, same clock
    input  wire logic [14:0] i_src_event,
    // Analog detector side
    input  wire logic        i_below_threshold,
    input  wire logic        i_lvr_enabled,
    input  wire logic        i_sleep,
    output logic             o_detector_power_on,
    output logic [2:0]       o_threshold_select,
    output logic             o_bandgap_on,
    // Core vectoring
    input  wire logic        i_ack,
    output logic             o_irq,
    output logic [3:0]       o_irq_id,
    output logic             o_wake
);

    // ========================================================================
    // Refuse delays that the 16-bit wait counter cannot count
    if (DLY_CYC < 32'h1 || DLY_CYC > 32'h0000ffff) begin : g_bad_dly
        $error("DLY_CYC out of range");
    end

    // ========================================================================
    // Registers
    logic [7:0]  lvd_ctrl_reg;
    logic [14:0] flag_reg;
    logic [14:0] en_reg;
    logic        gie_reg;
    logic        below_s1_reg;
    logic        below_s2_reg;
    logic        low_flag_reg;
    logic [15:0] dly_cnt_reg;
    lvic_pkg::lvic_det_type det_state_reg;
    logic [7:0]  rdata_reg;

    // Register select strobes
    wire wr_lvd = i_wr && (i_addr == lvic_pkg::ADDR_LVD_CTRL);
    wire wr_c0  = i_wr && (i_addr == lvic_pkg::ADDR_INT_CTRL0);
    wire wr_c1  = i_wr && (i_addr == lvic_pkg::ADDR_INT_CTRL1);
    wire wr_c2  = i_wr && (i_addr == lvic_pkg::ADDR_INT_CTRL2);
    wire wr_c3  = i_wr && (i_addr == lvic_pkg::ADDR_INT_CTRL3);

    // ========================================================================
    // Detector power and reference
    wire det_on = lvd_ctrl_reg[lvic_pkg::LVD_EN_BIT] && !i_sleep;
    assign o_detector_power_on = det_on;
    assign o_threshold_select  = lvd_ctrl_reg[lvic_pkg::THR_MSB:lvic_pkg::THR_LSB];
    assign o_bandgap_on = lvd_ctrl_reg[lvic_pkg::LVD_EN_BIT] || i_lvr_enabled
                        || lvd_ctrl_reg[lvic_pkg::BG_BUF_BIT];

    // Comparator output synchroniser
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            below_s1_reg <= 1'b0;
            below_s2_reg <= 1'b0;
        end else begin
            below_s1_reg <= i_below_threshold;
            below_s2_reg <= below_s1_reg;
        end
    end

    // Low-supply flag, zero while detector is off
    wire low_flag_next = det_on && below_s2_reg;
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            low_flag_reg <= 1'b0;
        end else begin
            low_flag_reg <= low_flag_next;
        end
    end

    // ========================================================================
    // Low-supply interrupt delay machine
    lvic_pkg::lvic_det_type det_state_next;
    logic [15:0] dly_cnt_next;
    logic        lvd_event;
    always_comb begin
        det_state_next = det_state_reg;
        dly_cnt_next   = dly_cnt_reg;
        lvd_event      = 1'b0;
        case (det_state_reg)
            lvic_pkg::DET_IDLE: begin
                dly_cnt_next = 16'h0000;
                if (low_flag_reg) begin
                    det_state_next = lvic_pkg::DET_WAIT;
                end
            end
            lvic_pkg::DET_WAIT: begin
                if (!low_flag_reg) begin
                    det_state_next = lvic_pkg::DET_IDLE;
                end else if (dly_cnt_reg == 16'(DLY_CYC - 1)) begin
                    lvd_event      = 1'b1;
                    det_state_next = lvic_pkg::DET_FIRED;
                end else begin
                    dly_cnt_next = dly_cnt_reg + 16'h0001;
                end
            end
            lvic_pkg::DET_FIRED: begin
                if (!low_flag_reg) begin
                    det_state_next = lvic_pkg::DET_IDLE;
                end
            end
            default: det_state_next = lvic_pkg::DET_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            det_state_reg <= lvic_pkg::DET_IDLE;
            dly_cnt_reg   <= 16'h0000;
        end else begin
            det_state_reg <= det_state_next;
            dly_cnt_reg   <= dly_cnt_next;
        end
    end

    // ========================================================================
    // Register mapping helpers: flag and enable vectors per byte
    function automatic logic [7:0] pack4(input logic [3:0] f, input logic [3:0] e);
        pack4 = {f, e};
    endfunction : pack4

    // Byte images, flags high nibble, enables low nibble
    wire [7:0] img_c0 = {1'b0, flag_reg[lvic_pkg::SRC_PPG_GEN], flag_reg[lvic_pkg::SRC_CMP1],
                         flag_reg[lvic_pkg::SRC_OVP], en_reg[lvic_pkg::SRC_PPG_GEN],
                         en_reg[lvic_pkg::SRC_CMP1], en_reg[lvic_pkg::SRC_OVP], gie_reg};
    wire [7:0] img_c1 = pack4({flag_reg[lvic_pkg::SRC_CMP3], flag_reg[lvic_pkg::SRC_CMP2],
                               flag_reg[lvic_pkg::SRC_ADC], flag_reg[lvic_pkg::SRC_TMR0]},
                              {en_reg[lvic_pkg::SRC_CMP3], en_reg[lvic_pkg::SRC_CMP2],
                               en_reg[lvic_pkg::SRC_ADC], en_reg[lvic_pkg::SRC_TMR0]});
    wire [7:0] img_c2 = pack4({flag_reg[lvic_pkg::SRC_EEPROM], flag_reg[lvic_pkg::SRC_TMR2],
                               flag_reg[lvic_pkg::SRC_TMR1], flag_reg[lvic_pkg::SRC_LVD]},
                              {en_reg[lvic_pkg::SRC_EEPROM], en_reg[lvic_pkg::SRC_TMR2],
                               en_reg[lvic_pkg::SRC_TMR1], en_reg[lvic_pkg::SRC_LVD]});
    wire [7:0] img_c3 = pack4({flag_reg[lvic_pkg::SRC_I2C], flag_reg[lvic_pkg::SRC_PPG_RETR],
                               flag_reg[lvic_pkg::SRC_PPG_CUT], flag_reg[lvic_pkg::SRC_PPG_TMR]},
                              {en_reg[lvic_pkg::SRC_I2C], en_reg[lvic_pkg::SRC_PPG_RETR],
                               en_reg[lvic_pkg::SRC_PPG_CUT], en_reg[lvic_pkg::SRC_PPG_TMR]});

    // ========================================================================
    // Priority selection over pending enabled requests
    wire [14:0] pend = flag_reg & en_reg;
    logic [3:0] pick;
    logic       any_pend;
    always_comb begin
        pick     = 4'h0;
        any_pend = 1'b0;
        for (int i = lvic_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick     = 4'(i);
                any_pend = 1'b1;
            end
        end
    end

    // Request, vector and wake outputs
    assign o_irq    = gie_reg && any_pend;
    assign o_irq_id = pick;
    assign o_wake   = |flag_reg;
    wire   take     = o_irq && i_ack;

    // ========================================================================
    // Write data split into flag and enable nibbles
    wire [3:0] wr_flags   = i_wdata[lvic_pkg::FLAG_MSB:lvic_pkg::FLAG_LSB];
    wire [3:0] wr_enables = i_wdata[lvic_pkg::EN_MSB:lvic_pkg::EN_LSB];

    // Software write image of the flag and enable vectors
    logic [14:0] sw_flag;
    logic [14:0] sw_en;
    logic        sw_gie;
    always_comb begin
        sw_flag = flag_reg;
        sw_en   = en_reg;
        sw_gie  = gie_reg;
        if (wr_c0) begin
            sw_gie                           = i_wdata[lvic_pkg::GIE_BIT];
            sw_en[lvic_pkg::SRC_OVP]         = i_wdata[lvic_pkg::C0_OVP_EN];
            sw_en[lvic_pkg::SRC_CMP1]        = i_wdata[lvic_pkg::C0_CMP1_EN];
            sw_en[lvic_pkg::SRC_PPG_GEN]     = i_wdata[lvic_pkg::C0_PPG_EN];
            sw_flag[lvic_pkg::SRC_OVP]       = i_wdata[lvic_pkg::C0_OVP_FLAG];
            sw_flag[lvic_pkg::SRC_CMP1]      = i_wdata[lvic_pkg::C0_CMP1_FLAG];
            sw_flag[lvic_pkg::SRC_PPG_GEN]   = i_wdata[lvic_pkg::C0_PPG_FLAG];
        end
        if (wr_c1) begin
            {sw_en[lvic_pkg::SRC_CMP3], sw_en[lvic_pkg::SRC_CMP2],
             sw_en[lvic_pkg::SRC_ADC], sw_en[lvic_pkg::SRC_TMR0]}       = wr_enables;
            {sw_flag[lvic_pkg::SRC_CMP3], sw_flag[lvic_pkg::SRC_CMP2],
             sw_flag[lvic_pkg::SRC_ADC], sw_flag[lvic_pkg::SRC_TMR0]}   = wr_flags;
        end
        if (wr_c2) begin
            {sw_en[lvic_pkg::SRC_EEPROM], sw_en[lvic_pkg::SRC_TMR2],
             sw_en[lvic_pkg::SRC_TMR1], sw_en[lvic_pkg::SRC_LVD]}       = wr_enables;
            {sw_flag[lvic_pkg::SRC_EEPROM], sw_flag[lvic_pkg::SRC_TMR2],
             sw_flag[lvic_pkg::SRC_TMR1], sw_flag[lvic_pkg::SRC_LVD]}   = wr_flags;
        end
        if (wr_c3) begin
            {sw_en[lvic_pkg::SRC_I2C], sw_en[lvic_pkg::SRC_PPG_RETR],
             sw_en[lvic_pkg::SRC_PPG_CUT], sw_en[lvic_pkg::SRC_PPG_TMR]}     = wr_enables;
            {sw_flag[lvic_pkg::SRC_I2C], sw_flag[lvic_pkg::SRC_PPG_RETR],
             sw_flag[lvic_pkg::SRC_PPG_CUT], sw_flag[lvic_pkg::SRC_PPG_TMR]} = wr_flags;
        end
    end

    // Hardware sets win over software and service clears
    logic [14:0] hw_set;
    logic [14:0] svc_clr;
    always_comb begin
        hw_set = i_src_event;
        hw_set[lvic_pkg::SRC_LVD] = i_src_event[lvic_pkg::SRC_LVD] | lvd_event;
        svc_clr = 15'h0000;
        if (take) begin
            svc_clr[pick] = 1'b1;
        end
    end
    wire [14:0] flag_next = (sw_flag & ~svc_clr) | hw_set;
    wire        gie_next  = sw_gie && !take;

    // Flag, enable and global enable storage
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            flag_reg <= 15'h0000;
            en_reg   <= 15'h0000;
            gie_reg  <= 1'b0;
        end else begin
            flag_reg <= flag_next;
            en_reg   <= sw_en;
            gie_reg  <= gie_next;
        end
    end

    // Low-voltage control register, flag bit is read-only
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            lvd_ctrl_reg <= lvic_pkg::REG_RESET;
        end else if (wr_lvd) begin
            lvd_ctrl_reg <= i_wdata & lvic_pkg::LVD_WR_MASK;
        end
    end

    // ========================================================================
    // Read data, registered one cycle after address
    logic [7:0] rd_mux;
    always_comb begin
        case (i_addr)
            lvic_pkg::ADDR_LVD_CTRL: begin
                rd_mux = lvd_ctrl_reg & lvic_pkg::LVD_WR_MASK;
                rd_mux[lvic_pkg::LVD_FLAG_BIT] = low_flag_reg;
            end
            lvic_pkg::ADDR_INT_CTRL0: rd_mux = img_c0 & lvic_pkg::INTERRUPT_CONTROL_0_WR_MASK;
            lvic_pkg::ADDR_INT_CTRL1: rd_mux = img_c1;
            lvic_pkg::ADDR_INT_CTRL2: rd_mux = img_c2;
            lvic_pkg::ADDR_INT_CTRL3: rd_mux = img_c3;
            default:                  rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rd_mux;
        end
    end
    assign o_rdata = rdata_reg;

endmodule : lvic_top

// [tb/lvic_top_monitor.sv]
// Port-level checks for the detector and interrupt control block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module lvic_top_monitor #(
    parameter int DLY_CYC = lvic_pkg::LOW_SUPPLY_DLY_CYC
) (
    // Clock and reset
    input wire logic        i_clk_sys,
    input wire logic        i_nrst,
    // Register port
    input wire logic [2:0]  i_addr,
    input wire logic        i_wr,
    input wire logic [7:0]  i_wdata,
    input wire logic [7:0]  o_rdata,
    // Events and detector
    input wire logic [14:0] i_src_event,
    input wire logic        i_below_threshold,
    input wire logic        i_lvr_enabled,
    input wire logic        i_sleep,
    input wire logic        o_detector_power_on,
    input wire logic [2:0]  o_threshold_select,
    input wire logic        o_bandgap_on,
    // Vectoring
    input wire logic        i_ack,
    input wire logic        o_irq,
    input wire logic [3:0]  o_irq_id,
    input wire logic        o_wake
);
    logic [15:0] low_cnt_reg;
    // ====================
    // Cycles of unbroken low supply with the detector powered
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst || !i_below_threshold || !o_detector_power_on)
            low_cnt_reg <= 16'h0000;
        else if (low_cnt_reg != 16'hffff)
            low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    // ====================
    // Properties
    property p_ack_blocks; i_ack && o_irq |=> !o_irq; endproperty
    a_ack_blocks: assert property (p_ack_blocks) else $error("irq held after acknowledge");
    property p_sleep_off; i_sleep |-> !o_detector_power_on; endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("detector powered in sleep");
    property p_bandgap; (o_detector_power_on || i_lvr_enabled) |-> o_bandgap_on; endproperty
    a_bandgap: assert property (p_bandgap) else $error("bandgap off while needed");
    property p_wake_irq; o_irq |-> o_wake; endproperty
    a_wake_irq: assert property (p_wake_irq) else $error("irq without wake");
    property p_event_flag; (i_src_event != 15'h0000) |=> o_wake; endproperty
    a_event_flag: assert property (p_event_flag) else $error("event left no flag");
    property p_unmapped; (i_addr > 3'h4) |=> (o_rdata == 8'h00); endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ctrl_top; (i_addr == 3'h0) |=> (o_rdata[7:6] == 2'b00); endproperty
    a_ctrl_top: assert property (p_ctrl_top) else $error("control top bits set");
    property p_thr_write; i_wr && (i_addr == 3'h0) |=> (o_threshold_select == $past(i_wdata[2:0])); endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold not written");
    property p_thr_hold; !(i_wr && (i_addr == 3'h0)) |=> $stable(o_threshold_select); endproperty
    a_thr_hold: assert property (p_thr_hold) else $error("threshold changed alone");
    property p_lvd_delay;
        $rose(o_wake) && ($past(i_src_event) == 15'h0000) && !$past(i_wr) |-> (low_cnt_reg >= DLY_CYC);
    endproperty
    a_lvd_delay: assert property (p_lvd_delay) else $error("low supply flag too early");
    c_ack: cover property (i_ack && o_irq);
    c_lvd: cover property ($rose(o_wake) && i_below_threshold);
    c_unmapped: cover property (i_addr == 3'h7);
endmodule : lvic_top_monitor

bind lvic_top lvic_top_monitor #(.DLY_CYC(DLY_CYC)) u_mon (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_src_event(i_src_event), .i_below_threshold(i_below_threshold),
    .i_lvr_enabled(i_lvr_enabled), .i_sleep(i_sleep), .o_detector_power_on(o_detector_power_on),
    .o_threshold_select(o_threshold_select), .o_bandgap_on(o_bandgap_on), .i_ack(i_ack),
    .o_irq(o_irq), .o_irq_id(o_irq_id), .o_wake(o_wake));

// [tb/lvic_core_model.sv]
// Behavioural core sequencer answering a request with one ack pulse.
// Assumes the request stays up until acknowledged.
`timescale 1ns/1ps
module lvic_core_model (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    // Control and request
    input  wire logic       i_enable,
    input  wire logic [3:0] i_delay,
    input  wire logic       i_irq,
    // Acknowledge
    output logic            o_ack = 1'b0
);
    logic [3:0] wait_reg = 4'h0;
    // Ack a live request after the chosen wait, one pulse only
    always @(posedge i_clk_sys) begin
        if (!i_nrst || o_ack || !i_enable || !i_irq) begin
            o_ack    <= 1'b0;
            wait_reg <= 4'h0;
        end else if (wait_reg == i_delay) begin
            o_ack <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule : lvic_core_model

// [tb/lvic_top_tb.sv]
// Self-checking bench: register traffic, events, service, detector.
// Assumes the package is compiled first and a 25 MHz clock.
`timescale 1ns/1ps
module lvic_top_tb;
    localparam int DLY = 8;
    localparam logic [7:0] POS [15] = '{8'h14, 8'h15, 8'h26, 8'h27, 8'h16, 8'h44, 8'h45, 8'h46,
                                        8'h25, 8'h37, 8'h34, 8'h24, 8'h35, 8'h36, 8'h47};
    logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, below = 1'b0, lvr = 1'b0, slp = 1'b0;
    logic        pen = 1'b0, lsf = 1'b0, ack, pwr, bg, irq, wake;
    logic [2:0]  addr = 3'h0, thr;
    logic [7:0]  wd = 8'h00, rdat, m [0:4] = '{default: 8'h00};
    logic [14:0] ev = 15'h0000, v;
    logic [3:0]  dly = 4'h0, id;
    logic [4:0]  pk;
    int          n_fail = 0, cmp_count = 0, seed = 32'h879c, i, k, s;
    always #20 clk = ~clk;
    lvic_top #(.DLY_CYC(DLY)) dut (.i_clk_sys(clk), .i_nrst(nrst), .i_addr(addr), .i_wr(wr),
        .i_wdata(wd), .o_rdata(rdat), .i_src_event(ev), .i_below_threshold(below), .i_lvr_enabled(lvr),
        .i_sleep(slp), .o_detector_power_on(pwr), .o_threshold_select(thr), .o_bandgap_on(bg),
        .i_ack(ack), .o_irq(irq), .o_irq_id(id), .o_wake(wake));
    lvic_core_model core (.i_clk_sys(clk), .i_nrst(nrst), .i_enable(pen), .i_delay(dly), .i_irq(irq),
        .o_ack(ack));
    // ====================
    // Expectation helpers
    function automatic logic [4:0] f_id();
        f_id = 5'h0f;
        for (int j = 14; j >= 0; j--)
            if (m[POS[j][6:4]][POS[j][2:0]] && m[POS[j][6:4]][POS[j][2:0] - ((POS[j][6:4] == 3'h1) ? 3 : 4)])
                f_id = {1'b1, 4'(j)};
    endfunction : f_id
    function automatic logic [7:0] f_rd(input logic [2:0] a);
        if (a == 3'h0) return {2'b00, lsf, m[0][4:0]};
        if (a < 3'h5) return m[a];
        return 8'h00;
    endfunction : f_rd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == 3'h0) m[0] = d & lvic_pkg::LVD_WR_MASK;
        else if (a == 3'h1) m[1] = d & lvic_pkg::INTERRUPT_CONTROL_0_WR_MASK;
        else if (a < 3'h5) m[a] = d;
    endtask : wr_reg
    task automatic check_all();
        for (int a = 0; a < 8; a++) begin
            @(posedge clk);
            addr <= 3'(a);
            @(posedge clk);
            #1 chk(rdat, f_rd(3'(a)));
        end
        pk = f_id();
        chk(irq, m[1][0] & pk[4]);
        if (irq === 1'b1) chk(id, pk[3:0]);
        chk(wake, |{m[1][6:4], m[2][7:4], m[3][7:4], m[4][7:4]});
        chk(thr, m[0][2:0]);
        chk(pwr, m[0][4] & ~slp);
        chk(bg, m[0][4] | m[0][3] | lvr);
    endtask : check_all
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // ====================
    // Watchdog
    initial begin
        #800000;
        n_fail++;
        tally_and_finish();
    end
    // ====================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        check_all();
        $display("reset values done");
        for (i = 0; i < 40; i++) begin
            wr_reg(3'($random(seed)), 8'($random(seed)));
            lvr <= 1'($random(seed));
            slp <= 1'($random(seed));
            check_all();
        end
        $display("register traffic done");
        for (i = 0; i < 30; i++) begin
            wr_reg(3'h1 + 3'(i % 4), 8'($random(seed)));
            v = 15'($random(seed));
            ev <= v;
            @(posedge clk);
            ev <= 15'h0000;
            for (s = 0; s < 15; s++) if (v[s]) m[POS[s][6:4]][POS[s][2:0]] = 1'b1;
            check_all();
            if (irq === 1'b1) begin
                pk = f_id();
                @(posedge clk);
                pen <= 1'b1;
                dly <= 4'($random(seed) & 3);
                k = 0;
                do begin @(posedge clk); #1 k++; end while (ack !== 1'b1 && k < 40);
                chk(8'(k < 40), 8'h01);
                chk(id, pk[3:0]);
                pen <= 1'b0;
                m[POS[pk[3:0]][6:4]][POS[pk[3:0]][2:0]] = 1'b0;
                m[1][0] = 1'b0;
                check_all();
            end
        end
        $display("events and service done");
        for (s = 1; s < 5; s++) wr_reg(3'(s), 8'h00);
        lvr <= 1'b0;
        slp <= 1'b0;
        wr_reg(3'h0, 8'h15);
        repeat (20) @(posedge clk);
        below <= 1'b1;
        repeat (DLY / 2) @(posedge clk);
        below <= 1'b0;
        repeat (DLY + 8) @(posedge clk);
        chk(wake, 8'h00);
        below <= 1'b1;
        k = 0;
        while (wake !== 1'b1 && k < 100) begin @(posedge clk); #1 k++; end
        chk(8'(k >= DLY && k <= DLY + 6), 8'h01);
        lsf = 1'b1;
        m[3][4] = 1'b1;
        check_all();
        @(posedge clk);
        slp <= 1'b1;
        lsf = 1'b0;
        repeat (4) @(posedge clk);
        check_all();
        $display("detector done");
        tally_and_finish();
    end
endmodule : lvic_top_tb
